// [bench/dtop_host.sv]
// host model issuing register accesses on the bank's port
`timescale 1ns/10ps
module dtop_host
  import dtop_pkg::*;
(
  input  wire logic       clock,
  output dtop_req_t       req,
  input  wire logic [7:0] rdata
);
  initial req = '0;
  // released lines show inverted garbage, never the old value
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(negedge clock);
    d = rdata;
  endtask
endmodule

// [bench/dtop_regs_properties.sv]
// checker: port timing of the operating-point register bank
`timescale 1ns/10ps
module dtop_regs_properties
  import dtop_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset_n,
  input dtop_req_t       req,
  input wire logic [7:0] rdata,
  input wire logic       cfg_lock,
  input wire logic       overtemp_pin_n,
  input wire logic       core_low_alert_mask,
  input dtop_ctl_t       ctl,
  input wire logic [7:0] peci_tgt,
  input wire logic [7:0] remote1_tgt,
  input wire logic [7:0] local_tgt,
  input wire logic [7:0] remote2_tgt,
  input wire logic       remote2_cycle_code_msb
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // target output trails the register by one cycle
  property p_lock;
    req.wr && cfg_lock && req.addr == 8'h8A |=> ##1 $stable(peci_tgt);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked write landed");
  // a locked control write must not reach the cycle code bit
  property p_lock_ctl;
    req.wr && cfg_lock && req.addr == 8'h8E
      |=> $stable(remote2_cycle_code_msb);
  endproperty
  a_lock_ctl: assert property (p_lock_ctl)
    else $error("locked control write landed");
  property p_peci_wr;
    req.wr && !cfg_lock && req.addr == 8'h8A
      |=> ##1 peci_tgt == $past(req.wdata, 2);
  endproperty
  a_peci_wr: assert property (p_peci_wr)
    else $error("peci write lost");
  property p_r2_wr;
    req.wr && !cfg_lock && req.addr == 8'h8D
      |=> ##1 remote2_tgt == $past(req.wdata, 2);
  endproperty
  a_r2_wr: assert property (p_r2_wr)
    else $error("remote2 write lost");
  property p_rd;
    req.rd && req.addr == 8'h8B |=> rdata == remote1_tgt;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read differs from target");
  property p_unmapped;
    req.rd && (req.addr < 8'h8A || req.addr > 8'h8E) |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read");
  // suspension must hit every function on the same edge
  property p_core_low;
    ctl.core_low_status |-> !(ctl.remote1_adaptive_enable
      || ctl.local_adaptive_enable || ctl.remote2_adaptive_enable
      || ctl.cpu_throttle_monitor || ctl.shutdown_allowed);
  endproperty
  a_core_low: assert property (p_core_low)
    else $error("not suspended");
  property p_alert;
    ctl.core_low_alert
      == (ctl.core_low_status && !$past(core_low_alert_mask));
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert mismatch");
  property p_cyc;
    $changed(remote2_cycle_code_msb) |-> $past(req.wr && req.addr == 8'h8E)
      || $past(req.wr && req.addr == 8'h8E, 2);
  endproperty
  a_cyc: assert property (p_cyc)
    else $error("cycle bit moved");
  // no pin and no write for three edges: targets may not move
  property p_quiet;
    (overtemp_pin_n && !req.wr)[*3]
      |=> ##1 $stable(remote1_tgt) && $stable(local_tgt);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("target moved");
endmodule

// [bench/test_dynamic_tmin_operating_point_regs.sv]
// testbench of the operating-point register bank
`timescale 1ns/10ps
module test_dynamic_tmin_operating_point_regs;
  import dtop_pkg::*;
  logic clock, reset_n, cfg_lock, pin_n, stby, below, mask, msb;
  dtop_req_t   req;
  dtop_temps_t temps;
  dtop_ctl_t   ctl;
  logic [7:0]  rdata, peci, r1, loc, r2, v;
  int          n_fail = 0, compares = 0, i;
  logic [7:0]  ofs [5] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E};
  logic [7:0]  rst [5] = '{DTOP_PECI_TGT_RST, DTOP_R1_TGT_RST,
    DTOP_LOC_TGT_RST, DTOP_R2_TGT_RST, DTOP_CTRL1_RST};
  dtop_host host (.clock(clock), .req(req), .rdata(rdata));
  dtop_regs dut (.clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
    .cfg_lock(cfg_lock), .temps(temps), .overtemp_pin_n(pin_n),
    .standby_power(stby), .core_below_limit(below),
    .core_low_alert_mask(mask), .ctl(ctl), .peci_tgt(peci),
    .remote1_tgt(r1), .local_tgt(loc), .remote2_tgt(r2),
    .remote2_cycle_code_msb(msb));
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.read(a, v);
    check(v, e);
  endtask
  task automatic pulse();
    @(posedge clock) pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    pin_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  function automatic logic [7:0] susp();
    return {1'b0, ctl.core_low_status, ctl.core_low_alert,
      ctl.remote1_adaptive_enable, ctl.local_adaptive_enable,
      ctl.remote2_adaptive_enable, ctl.cpu_throttle_monitor,
      ctl.shutdown_allowed};
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    {reset_n, cfg_lock, stby, below, mask} = '0;
    pin_n = 1'b1;
    temps = '{remote1: 8'h5A, local_t: 8'h33, remote2: 8'h2E};
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 5; i++) rchk(ofs[i], rst[i]);
    check(susp(), 8'h03);
    for (i = 0; i < 4; i++) host.write(ofs[i], 8'h10 + 8'(i));
    for (i = 0; i < 4; i++) rchk(ofs[i], 8'h10 + 8'(i));
    check(peci, 8'h10);
    check(r2, 8'h13);
    host.write(8'h8E, 8'h05);
    @(negedge clock);
    check({7'h00, msb}, 8'h01);
    pulse();
    rchk(8'h8B, 8'h5A);
    rchk(8'h8C, 8'h12);
    check(r1, 8'h5A);
    @(posedge clock);
    temps.remote1 <= 8'h60;
    host.write(8'h8E, 8'h08);
    pulse();
    rchk(8'h8B, 8'h5A);
    rchk(8'h8C, 8'h33);
    check({7'h00, msb}, 8'h00);
    check(loc, 8'h33);
    check(r1, 8'h5A);
    host.write(8'h8E, 8'hE2);
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(susp(), 8'h1F);
    @(posedge clock);
    stby <= 1'b1;
    below <= 1'b1;
    repeat (5) @(posedge clock);
    @(negedge clock);
    check(susp(), 8'h60);
    @(posedge clock);
    mask <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(susp(), 8'h40);
    @(posedge clock);
    below <= 1'b0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    check(susp(), 8'h1F);
    @(posedge clock);
    cfg_lock <= 1'b1;
    host.write(8'h8A, 8'hC3);
    host.write(8'h8E, 8'h01);
    rchk(8'h8A, 8'h10);
    rchk(8'h8E, 8'hE2);
    @(posedge clock);
    cfg_lock <= 1'b0;
    host.write(8'h8A, 8'hC3);
    rchk(8'h8A, 8'hC3);
    rchk(8'h89, 8'h00);
    rchk(8'h8F, 8'h00);
    tally_and_finish();
  end
  // watchdog cuts a hung run short
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
endmodule
bind dtop_regs dtop_regs_properties u_props (.clock(clock), .reset_n(reset_n),
  .req(req), .rdata(rdata), .cfg_lock(cfg_lock),
  .overtemp_pin_n(overtemp_pin_n), .core_low_alert_mask(core_low_alert_mask),
  .ctl(ctl), .peci_tgt(peci_tgt), .remote1_tgt(remote1_tgt),
  .local_tgt(local_tgt), .remote2_tgt(remote2_tgt),
  .remote2_cycle_code_msb(remote2_cycle_code_msb));

// [hdl/dtop_pkg.sv]
// package: register map, field layout and carriers of the operating-point bank
package dtop_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] DTOP_CFG1_OFS      = 8'h40;
  localparam logic [7:0] DTOP_PECI_TGT_OFS  = 8'h8A;
  localparam logic [7:0] DTOP_R1_TGT_OFS    = 8'h8B;
  localparam logic [7:0] DTOP_LOC_TGT_OFS   = 8'h8C;
  localparam logic [7:0] DTOP_R2_TGT_OFS    = 8'h8D;
  localparam logic [7:0] DTOP_CTRL1_OFS     = 8'h8E;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] DTOP_PECI_TGT_RST  = 8'hFB;
  localparam logic [7:0] DTOP_R1_TGT_RST    = 8'h64;
  localparam logic [7:0] DTOP_LOC_TGT_RST   = 8'h64;
  localparam logic [7:0] DTOP_R2_TGT_RST    = 8'h64;
  localparam logic [7:0] DTOP_CTRL1_RST     = 8'h00;

  // ----------------------------------------------------------------------
  // control register 1 field positions
  // ----------------------------------------------------------------------
  localparam int DTOP_CYC_MSB_BIT  = 0;
  localparam int DTOP_VLOW_BIT     = 1;
  localparam int DTOP_R1_HOLD_BIT  = 2;
  localparam int DTOP_LOC_HOLD_BIT = 3;
  localparam int DTOP_R2_HOLD_BIT  = 4;
  localparam int DTOP_R1_EN_BIT    = 5;
  localparam int DTOP_LOC_EN_BIT   = 6;
  localparam int DTOP_R2_EN_BIT    = 7;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  // one register-port access, sampled on the device clock
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtop_req_t;

  // current readings of the channels, same encoding as the targets
  typedef struct packed {
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
  } dtop_temps_t;

  // suspension and enable outputs toward the fan loop
  typedef struct packed {
    logic       remote1_adaptive_enable;
    logic       local_adaptive_enable;
    logic       remote2_adaptive_enable;
    logic       cpu_throttle_monitor;
    logic       shutdown_allowed;
    logic       core_low_status;
    logic       core_low_alert;
  } dtop_ctl_t;

endpackage

// [hdl/dtop_regs.sv]
// operating-point and adaptive floor control register bank
`timescale 1ns/10ps
module dtop_regs
  import dtop_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  dtop_req_t        req,
  output logic      [7:0]  rdata,
  input  wire logic        cfg_lock,
  input  dtop_temps_t      temps,
  input  wire logic        overtemp_pin_n,
  input  wire logic        standby_power,
  input  wire logic        core_below_limit,
  input  wire logic        core_low_alert_mask,
  output dtop_ctl_t        ctl,
  output logic      [7:0]  peci_tgt,
  output logic      [7:0]  remote1_tgt,
  output logic      [7:0]  local_tgt,
  output logic      [7:0]  remote2_tgt,
  output logic             remote2_cycle_code_msb
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // every register of the bank plus the registered outputs
  typedef struct packed {
    logic [7:0] peci_target_temp;
    logic [7:0] remote1_target_temp;
    logic [7:0] local_target_temp;
    logic [7:0] remote2_target_temp;
    logic [7:0] adaptive_floor_ctrl_one;
    logic [7:0] rdata;
    dtop_ctl_t  ctl;
    logic [7:0] peci_tgt;
    logic [7:0] remote1_tgt;
    logic [7:0] local_tgt;
    logic [7:0] remote2_tgt;
  } dtop_state_t;

  // registered state, its next value and the synchronised pin levels
  dtop_state_t state;
  dtop_state_t next_state;
  logic [2:0]  pins_sync;
  logic        overtemp_active;
  logic        standby_s;
  logic        core_below_s;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // all three pins come from the sensing front end, asynchronous to clock
  dtop_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in ({~overtemp_pin_n, standby_power, core_below_limit}),
    .sync_out (pins_sync)
  );

  // bit order follows the concatenation at the synchroniser input
  assign overtemp_active = pins_sync[2];
  assign standby_s       = pins_sync[1];
  assign core_below_s    = pins_sync[0];

  // ----------------------------------------------------------------------
  // read and hold-copy helpers
  // ----------------------------------------------------------------------
  // read mux shared by the register port; unmapped offsets, the lock
  // register among them, read as zero
  function automatic logic [7:0] read_reg(input dtop_state_t s,
                                          input logic [7:0]  a);
    case (a)
      DTOP_PECI_TGT_OFS: read_reg = s.peci_target_temp;
      DTOP_R1_TGT_OFS:   read_reg = s.remote1_target_temp;
      DTOP_LOC_TGT_OFS:  read_reg = s.local_target_temp;
      DTOP_R2_TGT_OFS:   read_reg = s.remote2_target_temp;
      DTOP_CTRL1_OFS:    read_reg = s.adaptive_floor_ctrl_one;
      default:           read_reg = 8'h00;
    endcase
  endfunction

  // hold-on-overtemp copy: the reading replaces the target every cycle
  // while the synchronised pin is active and the channel's hold bit is set
  function automatic logic [7:0] hold_copy(input logic       active,
                                           input logic       hold,
                                           input logic [7:0] reading,
                                           input logic [7:0] current);
    if (active && hold) begin
      hold_copy = reading;
    end else begin
      hold_copy = current;
    end
  endfunction

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  // one process for the whole next state; unmapped writes fall through
  always_comb begin
    logic       wr_ok;
    logic       core_low;
    logic [7:0] c1;
    wr_ok      = 1'b0;
    core_low   = 1'b0;
    c1         = 8'h00;
    next_state = state;

    // writes are dropped silently while locked; no error is signalled
    wr_ok = req.wr && !cfg_lock;
    if (wr_ok) begin
      case (req.addr)
        DTOP_PECI_TGT_OFS:
          next_state.peci_target_temp = req.wdata;
        DTOP_R1_TGT_OFS:
          next_state.remote1_target_temp = req.wdata;
        DTOP_LOC_TGT_OFS:
          next_state.local_target_temp = req.wdata;
        DTOP_R2_TGT_OFS:
          next_state.remote2_target_temp = req.wdata;
        DTOP_CTRL1_OFS:
          next_state.adaptive_floor_ctrl_one = req.wdata;
        default: ;
      endcase
    end

    // control fields act from the registered copy, one cycle after a write
    c1 = state.adaptive_floor_ctrl_one;

    // hardware copy wins over a same-cycle software write, so the
    // captured trip temperature is never lost
    next_state.remote1_target_temp =
      hold_copy(overtemp_active, c1[DTOP_R1_HOLD_BIT], temps.remote1,
                next_state.remote1_target_temp);
    next_state.local_target_temp =
      hold_copy(overtemp_active, c1[DTOP_LOC_HOLD_BIT], temps.local_t,
                next_state.local_target_temp);
    // the remote 2 hold bit is only stored; its copy sits with the
    // remote 2 channel logic outside this bank

    // core-low suspension is a level: it lifts when the voltage recovers
    // status and alert are levels; the sticky status bit is kept outside
    core_low = c1[DTOP_VLOW_BIT] && standby_s && core_below_s;
    next_state.ctl.core_low_status = core_low;
    next_state.ctl.core_low_alert  = core_low
                                     && !core_low_alert_mask;
    next_state.ctl.cpu_throttle_monitor = !core_low;
    next_state.ctl.shutdown_allowed     = !core_low;
    next_state.ctl.remote1_adaptive_enable =
      c1[DTOP_R1_EN_BIT] && !core_low;
    next_state.ctl.local_adaptive_enable =
      c1[DTOP_LOC_EN_BIT] && !core_low;
    next_state.ctl.remote2_adaptive_enable =
      c1[DTOP_R2_EN_BIT] && !core_low;

    // targets handed to the fan loop, one cycle behind the registers
    // the fan loop only acts on a target while its channel is enabled
    next_state.peci_tgt    = state.peci_target_temp;
    next_state.remote1_tgt = state.remote1_target_temp;
    next_state.local_tgt   = state.local_target_temp;
    next_state.remote2_tgt = state.remote2_target_temp;

    // rdata keeps the last read value between reads
    next_state.rdata = req.rd ? read_reg(state, req.addr) : state.rdata;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // async reset loads the power-on value of every register; the
  // adaptive enables stay low until software sets them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state                         <= '0;
      state.peci_target_temp        <= DTOP_PECI_TGT_RST;
      state.remote1_target_temp     <= DTOP_R1_TGT_RST;
      state.local_target_temp       <= DTOP_LOC_TGT_RST;
      state.remote2_target_temp     <= DTOP_R2_TGT_RST;
      state.adaptive_floor_ctrl_one <= DTOP_CTRL1_RST;
      state.peci_tgt                <= DTOP_PECI_TGT_RST;
      state.remote1_tgt             <= DTOP_R1_TGT_RST;
      state.local_tgt               <= DTOP_LOC_TGT_RST;
      state.remote2_tgt             <= DTOP_R2_TGT_RST;
      state.ctl.cpu_throttle_monitor <= 1'b1;
      state.ctl.shutdown_allowed     <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // outputs straight from flip-flops
  assign rdata       = state.rdata;
  assign ctl         = state.ctl;
  assign peci_tgt    = state.peci_tgt;
  assign remote1_tgt = state.remote1_tgt;
  assign local_tgt   = state.local_tgt;
  assign remote2_tgt = state.remote2_tgt;
  assign remote2_cycle_code_msb =
    state.adaptive_floor_ctrl_one[DTOP_CYC_MSB_BIT];

endmodule

// [hdl/dtop_sync.sv]
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module dtop_sync
  import dtop_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } dtop_sync_state_t;

  dtop_sync_state_t state;
  dtop_sync_state_t next_state;

  // first stage feeds only the second stage
  always_comb begin
    next_state.first  = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;

endmodule
